// file: rtl/pswm_regs.svh
// Purpose: constants of the panel switch mode logic
// Assumes: 250 MHz core clock
// Notes:   times in ms, counts derived from them
`ifndef PSWM_REGS_SVH
`define PSWM_REGS_SVH
`define PSWM_CLK_KHZ 250000
`define PSWM_ROUTE_HOLD_MS 5000
`define PSWM_ROUTE_HOLD_CYC (`PSWM_ROUTE_HOLD_MS * `PSWM_CLK_KHZ)
`define PSWM_STARTUP_MS 2000
`define PSWM_STARTUP_CYC (`PSWM_STARTUP_MS * `PSWM_CLK_KHZ)
`define PSWM_BYP_HOLD_MS 2000
`define PSWM_BYP_HOLD_CYC (`PSWM_BYP_HOLD_MS * `PSWM_CLK_KHZ)
`define PSWM_CLICK_MS 5
`define PSWM_CLICK_CYC (`PSWM_CLICK_MS * `PSWM_CLK_KHZ)
`define PSWM_FLASH_MS 100
`define PSWM_FLASH_CYC (`PSWM_FLASH_MS * `PSWM_CLK_KHZ)
`define PSWM_USER_HOLD_MS 500
`define PSWM_USER_HOLD_RST (`PSWM_USER_HOLD_MS * `PSWM_CLK_KHZ)
// key indices
`define PSWM_NKEYS 10
`define PSWM_K_ROUTE 0
`define PSWM_K_USER0 1
`define PSWM_K_TRANS 5
`define PSWM_K_BYP 6
`define PSWM_K_DRIVE 7
`define PSWM_K_EQ 8
`define PSWM_K_INS 9
`define PSWM_NUSER 4
// register offsets
`define PSWM_OFF_CTRL 4'h0
`define PSWM_OFF_HOLD 4'h4
`define PSWM_OFF_STAT 4'h8
// status fields
`define PSWM_ST_ROUTE 0
`define PSWM_ST_MODE 2
`define PSWM_ST_FB 5
`define PSWM_ST_BRIGHT 6
`define PSWM_ST_UMODE 9
`define PSWM_ST_ULATCH 13
// settings values
`define PSWM_BRIGHT_MAX 3'h4
`define PSWM_FB_RST 1'h1
`endif

// file: rtl/pswm_pkg.sv
// Purpose: types of the panel switch mode logic
// Assumes: nothing
// Notes:   binary codes written out
package pswm_pkg;
   typedef enum logic [1:0] {
      PSWM_RT_MIX_A  = 2'b00,
      PSWM_RT_SUBMIX = 2'b01,
      PSWM_RT_NONE   = 2'b10
   } pswm_route_type;
   typedef enum logic [2:0] {
      PSWM_M_LOAD  = 3'b000,
      PSWM_M_START = 3'b001,
      PSWM_M_NORM  = 3'b010,
      PSWM_M_PROG  = 3'b011,
      PSWM_M_SET   = 3'b100,
      PSWM_M_BOOT  = 3'b101
   } pswm_mode_type;
endpackage : pswm_pkg

// file: rtl/pswm_key_if.sv
// Purpose: key events from the key timer to the control logic
// Assumes: one clock domain
// Notes:   press and release are one-cycle pulses
`timescale 1ns/1ps
interface pswm_key_if;
   logic [9:0]       held;
   logic [9:0]       press;
   logic [9:0]       rel;
   logic [9:0][31:0] cnt;
   modport src (output held, press, rel, cnt);
   modport dst (input held, press, rel, cnt);
endinterface : pswm_key_if

// file: rtl/pswm_key_timer.sv
// Purpose: synchronise panel keys and count hold time
// Assumes: key pins high while pressed
// Notes:   count holds its value in the release cycle
`timescale 1ns/1ps
`include "pswm_regs.svh"
module pswm_key_timer (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_b,
   // panel keys
   input wire logic [9:0] key_pin,
   // events out
   pswm_key_if.src        kb
);
   typedef struct packed {
      logic [9:0]       s1;
      logic [9:0]       s2;
      logic [9:0]       prev;
      logic [9:0][31:0] cnt;
   } pswm_kt_type;
   pswm_kt_type      st;
   pswm_kt_type      next_st;
   logic [9:0][31:0] next_cnt;

   // per key saturating hold counter
   genvar g;
   generate
      for (g = 0; g < `PSWM_NKEYS; g++) begin : g_key
         assign next_cnt[g] = !st.s2[g] ? 32'h0 :
                              (&st.cnt[g]) ? st.cnt[g] : st.cnt[g] + 32'h1;
      end
   endgenerate

   // next state
   always_comb begin
      next_st      = st;
      next_st.s1   = key_pin;
      next_st.s2   = st.s1;
      next_st.prev = st.s2;
      next_st.cnt  = next_cnt;
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // event outputs
   assign kb.held  = st.s2;
   assign kb.press = st.s2 & ~st.prev;
   assign kb.rel   = ~st.s2 & st.prev;
   assign kb.cnt   = st.cnt;
endmodule : pswm_key_timer

// file: rtl/pswm_panel.sv
// Purpose: routing, user switch and settings control of the panel
// Assumes: keys high while pressed; store valid before reset release
// Notes: registers on a plain strobe port, read data one cycle later
// Notes on behaviour
// RULE_01: routing key press cycles mix A, submix, unrouted in turn.
// RULE_02: unrouted passes insert returns straight through to the console.
// RULE_03: in surround mode mix A is front L/R, submix is fold-down.
// RULE_04: four user switches drive relays; LED local or tally input.
// RULE_05: user switch plain momentary, or combined short-toggle long-momentary.
// RULE_06: routing key held 5 s enters programming, mix A LED flashing.
// RULE_07: in programming LED solid for plain, off for combined mode.
// RULE_08: quick routing key press in programming leaves programming.
// RULE_09: transformer and bypass held at power-up enter settings mode.
// RULE_10: settings stored and restored on every reboot.
// RULE_11: five brightness levels; drive-in lowers, EQ-in raises by one.
// RULE_12: drive-in LED dark at minimum, EQ-in LED dark at maximum.
// RULE_13: brightness defaults to maximum.
// RULE_14: brightness not applied during the power-up sequence.
// RULE_15: insert toggles relay feedback; blue enabled, white off; click.
// RULE_16: relay feedback gates clicks at power-up and in use; default on.
// RULE_17: holding bypass in settings leaves by rebooting.
// RULE_18: user press in programming toggles its mode and LED at once.
// RULE_19: short/long boundary is a register threshold in cycles.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pswm_regs.svh"
module pswm_panel #(
   parameter int unsigned ROUTE_HOLD_CYC = `PSWM_ROUTE_HOLD_CYC,
   parameter int unsigned STARTUP_CYC    = `PSWM_STARTUP_CYC,
   parameter int unsigned BYP_HOLD_CYC   = `PSWM_BYP_HOLD_CYC,
   parameter int unsigned CLICK_CYC      = `PSWM_CLICK_CYC,
   parameter int unsigned FLASH_CYC      = `PSWM_FLASH_CYC
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // panel pins
   input  wire logic [9:0]  key_pin,
   input  wire logic [3:0]  tally_pin,
   input  wire logic        surround_pin,
   // settings store
   input  wire logic [3:0]  store_rdata,
   input  wire logic        store_valid,
   output logic      [3:0]  store_wdata,
   output logic             store_wr,
   // routing
   output logic             mix_a_led,
   output logic             submix_led,
   output logic             mix_a_ins,
   output logic             submix_ins,
   output logic             front_lr_ins,
   output logic             fold_ins,
   output logic             direct_ret,
   // user switches
   output logic      [3:0]  user_relay,
   output logic      [3:0]  user_led,
   // settings indication
   output logic             drive_in_led,
   output logic             eq_in_led,
   output logic             ins_white,
   output logic             ins_blue,
   output logic             click_relay,
   output logic      [2:0]  led_bright,
   output logic             reboot_req
);
   typedef struct packed {
      pswm_pkg::pswm_mode_type  mode;
      pswm_pkg::pswm_route_type route;
      logic [31:0] tcnt;
      logic [31:0] fcnt;
      logic        flash;
      logic [31:0] ccnt;
      logic [2:0]  bright;
      logic        fb;
      logic [3:0]  umode;
      logic [3:0]  ulatch;
      logic [3:0]  tsel;
      logic [31:0] thr;
      logic        sur1;
      logic        sur2;
      logic [3:0]  tal1;
      logic [3:0]  tal2;
      logic [31:0] rdata;
      logic [3:0]  sdata;
      logic        swr;
      logic [6:0]  rt_o;
      logic [3:0]  relay;
      logic [3:0]  uled;
      logic [4:0]  set_o;
      logic [2:0]  bri_o;
      logic        boot;
   } pswm_pan_type;

   pswm_pan_type st;
   pswm_pan_type next_st;
   pswm_key_if   kb ();

   // key synchroniser and hold counters
   pswm_key_timer u_keys (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .key_pin  (key_pin),
      .kb       (kb.src)
   );

   // next state
   always_comb begin
      next_st       = st;
      next_st.rdata = 32'h0;
      next_st.swr   = 1'b0;
      next_st.sur1  = surround_pin;
      next_st.sur2  = st.sur1;
      next_st.tal1  = tally_pin;
      next_st.tal2  = st.tal1;
      // fast flash for programming indication
      if (st.fcnt >= 32'(FLASH_CYC - 1)) begin
         next_st.fcnt  = 32'h0;
         next_st.flash = ~st.flash;
      end else begin
         next_st.fcnt = st.fcnt + 32'h1;
      end
      if (st.ccnt != 32'h0) begin
         next_st.ccnt = st.ccnt - 32'h1;
      end
      // register writes
      if (reg_wr) begin
         if (reg_addr == `PSWM_OFF_CTRL) begin
            next_st.tsel = reg_wdata[3:0];
         end else if (reg_addr == `PSWM_OFF_HOLD) begin
            next_st.thr = reg_wdata; // see RULE_19
         end
      end
      // register reads
      if (reg_rd) begin
         if (reg_addr == `PSWM_OFF_CTRL) begin
            next_st.rdata = {28'h0, st.tsel};
         end else if (reg_addr == `PSWM_OFF_HOLD) begin
            next_st.rdata = st.thr;
         end else if (reg_addr == `PSWM_OFF_STAT) begin
            next_st.rdata = {15'h0, st.ulatch, st.umode, st.bright, st.fb,
                             st.mode, st.route};
         end
      end
      // key clicks in use
      if ((st.mode == pswm_pkg::PSWM_M_NORM || st.mode == pswm_pkg::PSWM_M_PROG)
          && (|kb.press) && st.fb) begin
         next_st.ccnt = 32'(CLICK_CYC); // see RULE_16
      end
      case (st.mode)
         pswm_pkg::PSWM_M_LOAD: begin
            if (store_valid) begin // see RULE_10
               next_st.bright = (store_rdata[2:0] > `PSWM_BRIGHT_MAX) ?
                                `PSWM_BRIGHT_MAX : store_rdata[2:0];
               next_st.fb     = store_rdata[3];
            end
            next_st.tcnt = 32'h0;
            next_st.mode = pswm_pkg::PSWM_M_START;
         end
         pswm_pkg::PSWM_M_START: begin
            next_st.tcnt = st.tcnt + 32'h1;
            if (st.tcnt == 32'h0 && st.fb) begin
               next_st.ccnt = 32'(CLICK_CYC); // see RULE_16
            end
            if (st.tcnt >= 32'(STARTUP_CYC - 1)) begin
               if (kb.held[`PSWM_K_TRANS] && kb.held[`PSWM_K_BYP]) begin
                  next_st.mode = pswm_pkg::PSWM_M_SET; // see RULE_09
               end else begin
                  next_st.mode = pswm_pkg::PSWM_M_NORM;
               end
            end
         end
         pswm_pkg::PSWM_M_NORM: begin
            if (kb.rel[`PSWM_K_ROUTE] &&
                kb.cnt[`PSWM_K_ROUTE] < 32'(ROUTE_HOLD_CYC)) begin
               case (st.route) // see RULE_01
                  pswm_pkg::PSWM_RT_MIX_A:  next_st.route = pswm_pkg::PSWM_RT_SUBMIX;
                  pswm_pkg::PSWM_RT_SUBMIX: next_st.route = pswm_pkg::PSWM_RT_NONE;
                  default:                  next_st.route = pswm_pkg::PSWM_RT_MIX_A;
               endcase
            end
            if (kb.held[`PSWM_K_ROUTE] &&
                kb.cnt[`PSWM_K_ROUTE] == 32'(ROUTE_HOLD_CYC - 1)) begin
               next_st.mode = pswm_pkg::PSWM_M_PROG; // see RULE_06
            end
         end
         pswm_pkg::PSWM_M_PROG: begin
            if (kb.rel[`PSWM_K_ROUTE] &&
                kb.cnt[`PSWM_K_ROUTE] < 32'(ROUTE_HOLD_CYC)) begin
               next_st.mode = pswm_pkg::PSWM_M_NORM; // see RULE_08
            end
            // see RULE_18
            next_st.umode = st.umode ^ kb.press[`PSWM_K_USER0 +: `PSWM_NUSER];
         end
         pswm_pkg::PSWM_M_SET: begin
            if (kb.press[`PSWM_K_DRIVE] && st.bright != 3'h0) begin
               next_st.bright = st.bright - 3'h1; // see RULE_11
            end else if (kb.press[`PSWM_K_EQ] && st.bright < `PSWM_BRIGHT_MAX) begin
               next_st.bright = st.bright + 3'h1; // see RULE_11
            end
            if (kb.press[`PSWM_K_INS]) begin
               next_st.fb = ~st.fb; // see RULE_15
               if (!st.fb) begin
                  next_st.ccnt = 32'(CLICK_CYC); // see RULE_15
               end
            end
            if (kb.held[`PSWM_K_BYP] &&
                kb.cnt[`PSWM_K_BYP] == 32'(BYP_HOLD_CYC - 1)) begin
               next_st.swr   = 1'b1; // see RULE_10
               next_st.sdata = {st.fb, st.bright};
               next_st.mode  = pswm_pkg::PSWM_M_BOOT; // see RULE_17
            end
         end
         default: begin
            next_st.mode = pswm_pkg::PSWM_M_BOOT;
         end
      endcase
      // user switches and their LEDs
      for (int i = 0; i < `PSWM_NUSER; i++) begin
         if (st.mode == pswm_pkg::PSWM_M_NORM && st.umode[i] &&
             kb.rel[`PSWM_K_USER0 + i] && kb.cnt[`PSWM_K_USER0 + i] < st.thr) begin
            next_st.ulatch[i] = ~st.ulatch[i]; // see RULE_05
         end
         if (st.mode != pswm_pkg::PSWM_M_NORM) begin
            next_st.relay[i] = st.umode[i] & st.ulatch[i];
         end else if (st.umode[i]) begin
            next_st.relay[i] = st.ulatch[i] | (kb.held[`PSWM_K_USER0 + i] &&
                               kb.cnt[`PSWM_K_USER0 + i] >= st.thr); // see RULE_05
         end else begin
            next_st.relay[i] = kb.held[`PSWM_K_USER0 + i]; // see RULE_04
         end
         if (st.mode == pswm_pkg::PSWM_M_PROG) begin
            next_st.uled[i] = ~next_st.umode[i]; // see RULE_07
         end else begin
            next_st.uled[i] = st.tsel[i] ? st.tal2[i] : next_st.relay[i];
         end
      end
      // routing selects, see RULE_02 and RULE_03
      next_st.rt_o[0] = (st.mode == pswm_pkg::PSWM_M_PROG) ? st.flash :
                        (st.route == pswm_pkg::PSWM_RT_MIX_A);
      next_st.rt_o[1] = st.route == pswm_pkg::PSWM_RT_SUBMIX;
      next_st.rt_o[2] = st.route == pswm_pkg::PSWM_RT_MIX_A && !st.sur2;
      next_st.rt_o[3] = st.route == pswm_pkg::PSWM_RT_SUBMIX && !st.sur2;
      next_st.rt_o[4] = st.route == pswm_pkg::PSWM_RT_MIX_A && st.sur2;
      next_st.rt_o[5] = st.route == pswm_pkg::PSWM_RT_SUBMIX && st.sur2;
      next_st.rt_o[6] = st.route == pswm_pkg::PSWM_RT_NONE;
      // settings indication, see RULE_12 and RULE_15
      next_st.set_o = 5'h0;
      if (st.mode == pswm_pkg::PSWM_M_SET) begin
         next_st.set_o = {st.ccnt != 32'h0, st.fb, !st.fb,
                          st.bright != `PSWM_BRIGHT_MAX, st.bright != 3'h0};
      end else begin
         next_st.set_o[4] = st.ccnt != 32'h0;
      end
      // brightness held at full during power-up
      if (st.mode == pswm_pkg::PSWM_M_LOAD || st.mode == pswm_pkg::PSWM_M_START) begin
         next_st.bri_o = `PSWM_BRIGHT_MAX; // see RULE_14
      end else begin
         next_st.bri_o = st.bright;
      end
      next_st.boot = st.mode == pswm_pkg::PSWM_M_BOOT;
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st        <= '0;
         st.mode   <= pswm_pkg::PSWM_M_LOAD;
         st.route  <= pswm_pkg::PSWM_RT_NONE;
         st.bright <= `PSWM_BRIGHT_MAX; // see RULE_13
         st.fb     <= `PSWM_FB_RST; // see RULE_16
         st.thr    <= 32'(`PSWM_USER_HOLD_RST);
         st.rt_o   <= 7'h40;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign reg_rdata    = st.rdata;
   assign store_wdata  = st.sdata;
   assign store_wr     = st.swr;
   assign mix_a_led    = st.rt_o[0];
   assign submix_led   = st.rt_o[1];
   assign mix_a_ins    = st.rt_o[2];
   assign submix_ins   = st.rt_o[3];
   assign front_lr_ins = st.rt_o[4];
   assign fold_ins     = st.rt_o[5];
   assign direct_ret   = st.rt_o[6];
   assign user_relay   = st.relay;
   assign user_led     = st.uled;
   assign drive_in_led = st.set_o[0];
   assign eq_in_led    = st.set_o[1];
   assign ins_white    = st.set_o[2];
   assign ins_blue     = st.set_o[3];
   assign click_relay  = st.set_o[4];
   assign led_bright   = st.bri_o;
   assign reboot_req   = st.boot;

   // checks
   AST_ROUTE_CYCLE: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_01
      st.mode == pswm_pkg::PSWM_M_NORM && st.route == pswm_pkg::PSWM_RT_NONE &&
      kb.rel[0] && kb.cnt[0] < 32'(ROUTE_HOLD_CYC)
      |=> st.route == pswm_pkg::PSWM_RT_MIX_A ##1 mix_a_led && mix_a_ins != st.sur2)
      else $error("routing did not advance to mix A");
   AST_UNROUTED: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_02
      st.route == pswm_pkg::PSWM_RT_NONE |=> direct_ret && !mix_a_ins && !submix_ins)
      else $error("unrouted state not passing returns");
   AST_SURROUND: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_03
      st.route == pswm_pkg::PSWM_RT_SUBMIX && st.sur2 |=> fold_ins && !submix_ins)
      else $error("surround submix not in fold-down");
   AST_PROG_ENTER: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_06
      st.mode == pswm_pkg::PSWM_M_NORM && kb.held[0] &&
      kb.cnt[0] == 32'(ROUTE_HOLD_CYC - 1) |=> st.mode == pswm_pkg::PSWM_M_PROG)
      else $error("long routing hold did not enter programming");
   AST_PROG_EXIT: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_08
      st.mode == pswm_pkg::PSWM_M_PROG && kb.rel[0] && kb.cnt[0] < 32'(ROUTE_HOLD_CYC)
      |=> st.mode == pswm_pkg::PSWM_M_NORM)
      else $error("quick press did not leave programming");
   AST_PROG_LED: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_18
      st.mode == pswm_pkg::PSWM_M_PROG && kb.press[1] && !kb.rel[0]
      |=> user_led[0] == !st.umode[0] && st.umode[0] != $past(st.umode[0]))
      else $error("programming press did not toggle mode");
   AST_PLAIN: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_05
      st.mode == pswm_pkg::PSWM_M_NORM && !st.umode[2] && kb.held[3]
      |=> user_relay[2])
      else $error("plain switch relay not following key");
   AST_SETTINGS: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_09
      st.mode == pswm_pkg::PSWM_M_START && st.tcnt >= 32'(STARTUP_CYC - 1) &&
      kb.held[5] && kb.held[6] |=> st.mode == pswm_pkg::PSWM_M_SET)
      else $error("settings mode not entered");
   AST_BRIGHT_DN: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_11
      st.mode == pswm_pkg::PSWM_M_SET && kb.press[7] && st.bright != 3'h0
      |=> st.bright == $past(st.bright) - 3'h1 ##1 led_bright == st.bright)
      else $error("drive-in did not lower brightness");
   AST_BRIGHT_LIM: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_12
      st.mode == pswm_pkg::PSWM_M_SET && st.bright == `PSWM_BRIGHT_MAX
      |=> !eq_in_led && drive_in_led)
      else $error("EQ-in LED lit at maximum");
   AST_START_BRIGHT: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_14
      st.mode == pswm_pkg::PSWM_M_START |=> led_bright == `PSWM_BRIGHT_MAX)
      else $error("brightness applied during power-up");
   AST_FB_CLICK: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_15
      st.mode == pswm_pkg::PSWM_M_SET && kb.press[9] && !st.fb
      |=> st.fb ##1 click_relay && ins_blue)
      else $error("feedback enable gave no click");
   AST_STORE: assert property (@(posedge core_clk) disable iff (!rst_b) // see RULE_17
      store_wr |-> reboot_req == 1'b0 ##1 reboot_req)
      else $error("store write not followed by reboot");
endmodule : pswm_panel

// file: verif/pswm_operator.sv
// Purpose: operator at the panel, pressing and holding keys
// Assumes: keys high while pressed
// Notes:   tasks are called from the bench
`timescale 1ns/1ps
module pswm_operator (
   // clock
   input wire logic       core_clk,
   // panel keys
   output logic     [9:0] key_pin
);
   // no key pressed at power-on
   initial key_pin = 10'h000;
   task down(input int k);
      @(posedge core_clk);
      key_pin[k] <= 1'b1;
   endtask : down
   task up(input int k);
      @(posedge core_clk);
      key_pin[k] <= 1'b0;
   endtask : up
   // press for n+1 cycles, then let the outputs settle
   task tap(input int k, input int n);
      down(k);
      repeat (n) @(posedge core_clk);
      up(k);
      repeat (8) @(posedge core_clk);
   endtask : tap
endmodule : pswm_operator

// file: verif/panel_switch_mode_logic_bench.sv
// Purpose: self-checking bench of the panel switch mode logic
// Assumes: shortened hold and startup counts
// Notes:   reads checked from a queue of expected words
`timescale 1ns/1ps
module panel_switch_mode_logic_bench;
   logic        core_clk, rst_b, reg_wr, reg_rd, surround_pin, store_valid, store_wr;
   logic        mix_a_led, submix_led, mix_a_ins, submix_ins, front_lr_ins, fold_ins;
   logic        direct_ret, drive_in_led, eq_in_led, ins_white, ins_blue, click_relay;
   logic        reboot_req, rd_d, s, a;
   logic [3:0]  reg_addr, tally_pin, store_rdata, store_wdata, user_relay, user_led;
   logic [31:0] reg_wdata, reg_rdata, t;
   logic [2:0]  led_bright;
   logic [9:0]  key_pin;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   int          error_cnt = 0;
   int          check_count = 0;
   pswm_operator op_inst (.core_clk(core_clk), .key_pin(key_pin));
   pswm_panel #(.ROUTE_HOLD_CYC(40), .STARTUP_CYC(20), .BYP_HOLD_CYC(60), .CLICK_CYC(3),
      .FLASH_CYC(4)) pswm_panel_inst (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .key_pin(key_pin), .tally_pin(tally_pin),
      .surround_pin(surround_pin), .store_rdata(store_rdata), .store_valid(store_valid),
      .store_wdata(store_wdata), .store_wr(store_wr), .mix_a_led(mix_a_led),
      .submix_led(submix_led), .mix_a_ins(mix_a_ins), .submix_ins(submix_ins),
      .front_lr_ins(front_lr_ins), .fold_ins(fold_ins), .direct_ret(direct_ret),
      .user_relay(user_relay), .user_led(user_led), .drive_in_led(drive_in_led),
      .eq_in_led(eq_in_led), .ins_white(ins_white), .ins_blue(ins_blue),
      .click_relay(click_relay), .led_bright(led_bright), .reboot_req(reboot_req));
   // clock generation
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] expd);
      check_count++;
      if (seen !== expd) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask : chk
   task summarize;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= ad;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // note the expected masked word, then issue the read
   task rd(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] x);
      exp_q.push_back({m, x});
      @(posedge core_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : rd
   task rst(input logic v, input logic [3:0] d);
      @(posedge core_clk);
      rst_b       <= 1'b0;
      store_valid <= v;
      store_rdata <= d;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
   endtask : rst
   // read data stand only in the cycle after the strobe
   always @(posedge core_clk) rd_d <= reg_rd;
   always @(negedge core_clk) begin
      if (rd_d === 1'b1) begin
         e = exp_q.pop_front();
         chk(reg_rdata & e[63:32], e[31:0]);
      end
   end
   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end
   // main sequence
   initial begin
      t = $urandom(70396);
      {rst_b, reg_wr, reg_rd, store_valid} = '0;
      // idle bus and pins start from random values
      reg_addr     = 4'($urandom);
      reg_wdata    = $urandom;
      tally_pin    = 4'($urandom);
      surround_pin = 1'($urandom);
      store_rdata  = 4'($urandom);
      rst(1'b0, 4'h0);
      repeat (30) @(posedge core_clk);
      rd(4'h4, 32'hFFFFFFFF, 32'h07735940);
      rd(4'hC, 32'hFFFFFFFF, 32'h00000000);
      rd(4'h8, 32'h0001FFFF, 32'h0000012A);
      $display("test reset done");
      // two rounds of the routing cycle, surround flipped in the second
      a = 1'($urandom);
      for (int i = 0; i < 6; i++) begin
         s = a ^ (i > 2);
         surround_pin <= s;
         op_inst.tap(0, 2);
         t = (i % 3 == 0) ? {25'h0, 3'h4, !s, 1'b0, s, 1'b0} :
             (i % 3 == 1) ? {25'h0, 3'h2, 1'b0, !s, 1'b0, s} : 32'h10;
         chk({mix_a_led, submix_led, direct_ret, mix_a_ins, submix_ins, front_lr_ins,
            fold_ins}, t);
      end
      $display("test route done");
      op_inst.tap(0, 50);
      rd(4'h8, 32'h1C, 32'hC);
      chk(user_led, 4'hF);
      a = mix_a_led;
      repeat (4) @(posedge core_clk);
      chk(mix_a_led, !a);
      op_inst.tap(1, 2);
      chk(user_led, 4'hE);
      op_inst.tap(0, 2);
      rd(4'h8, 32'h1E1C, 32'h208);
      $display("test programming done");
      wr(4'h4, 32'hA);
      op_inst.tap(1, 2);
      chk(user_relay[0], 1'b1);
      op_inst.tap(1, 2);
      chk(user_relay[0], 1'b0);
      op_inst.down(1);
      op_inst.down(2);
      repeat (20) @(posedge core_clk);
      chk(user_relay[1:0], 2'h3);
      op_inst.tap(1, 0);
      op_inst.tap(2, 0);
      chk(user_relay[1:0], 2'h0);
      t = $urandom;
      tally_pin <= t[3:0];
      wr(4'h0, 32'hF);
      repeat (8) @(posedge core_clk);
      chk(user_led, t[3:0]);
      $display("test user switches done");
      rst(1'b0, 4'h0);
      op_inst.down(5);
      op_inst.down(6);
      repeat (30) @(posedge core_clk);
      op_inst.up(5);
      op_inst.tap(6, 0);
      rd(4'h8, 32'h1C, 32'h10);
      chk({drive_in_led, eq_in_led, ins_blue}, 3'h5);
      for (int i = 0; i < 5; i++)
         op_inst.tap(7, 2);
      chk(drive_in_led, 1'b0);
      op_inst.tap(8, 2);
      rd(4'h8, 32'h1C0, 32'h40);
      op_inst.tap(9, 2);
      chk({ins_white, ins_blue}, 2'h2);
      op_inst.down(9);
      op_inst.up(9);
      a = 1'b0;
      for (int i = 0; i < 12; i++) begin
         @(negedge core_clk);
         a = a | click_relay;
      end
      chk({a, ins_blue}, 2'h3);
      op_inst.down(6);
      a = 1'b0;
      for (int i = 0; i < 100 && !a; i++) begin
         @(negedge core_clk);
         a = store_wr;
      end
      chk({a, store_wdata}, 5'h19);
      op_inst.up(6);
      repeat (3) @(posedge core_clk);
      chk(reboot_req, 1'b1);
      $display("test settings done");
      rst(1'b1, 4'h1);
      repeat (6) @(posedge core_clk);
      chk(led_bright, 3'h4);
      repeat (30) @(posedge core_clk);
      rd(4'h8, 32'h1FC, 32'h48);
      chk(led_bright, 3'h1);
      $display("test restore done");
      summarize();
   end
endmodule : panel_switch_mode_logic_bench
